// >>> hw/pcsi_pkg.sv
// Purpose: Shared constants and carriers for the program counter, return stack and indirect addressing
// Assumes: One core clock, decoder supplies one-cycle command strobes
// Notes:   Widths are the documented ones
package pcsi_pkg;

    // ==========================================================
    // Widths and constants
    localparam int PC_W        = 13;
    localparam int BYTE_W      = 8;
    localparam int HI_W        = 5;
    localparam int OPER_W      = 11;
    localparam int DADDR_W     = 9;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;

    localparam logic [PC_W-1:0]    PC_RESET     = 13'h0000;
    localparam logic [BYTE_W-1:0]  ZERO_BYTE    = 8'h00;
    localparam logic [BYTE_W-1:0]  IND_PORT_ADR = 8'h00;
    localparam logic [SP_W-1:0]    SP_RESET     = 3'h0;
    localparam logic [SP_W-1:0]    SP_ONE       = 3'h1;
    localparam logic [HI_W-1:0]    HI_RESET     = 5'h00;
    localparam logic [PC_W-1:0]    PC_ONE       = 13'h0001;

    // ==========================================================
    // Program counter load source
    typedef enum logic [2:0] {
        PCSI_LD_STEP  = 3'b000,
        PCSI_LD_LOW   = 3'b001,
        PCSI_LD_JUMP  = 3'b010,
        PCSI_LD_CALL  = 3'b011,
        PCSI_LD_VEC   = 3'b100,
        PCSI_LD_RET   = 3'b101,
        PCSI_LD_HOLD  = 3'b110
    } pcsi_load_t;

    // ==========================================================
    // Decoder command carrier
    typedef struct packed {
        logic              advance;
        logic              writeLow;
        logic              directJump;
        logic              callBranch;
        logic              intVector;
        logic              returnPop;
        logic [OPER_W-1:0] operand;
        logic [BYTE_W-1:0] lowData;
    } pcsi_cmd_t;

    // Indirect access carrier
    typedef struct packed {
        logic              read;
        logic              write;
        logic [BYTE_W-1:0] wdata;
    } pcsi_ind_t;

endpackage

// >>> hw/pcsi_return_stack.sv
// Purpose: Circular eight-entry return address stack
// Assumes: Push and pop are never asserted together
// Notes:   Pointer is internal only, no wrap indication
`timescale 1ns/1ps
module pcsi_return_stack #(
    parameter int DEPTH = pcsi_pkg::STACK_DEPTH,
    parameter int WIDTH = pcsi_pkg::PC_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Stack operations
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] pushData,
    output logic      [WIDTH-1:0] topData
);
    localparam int AW = $clog2(DEPTH);

    logic [AW-1:0]    stackPtr;
    logic [WIDTH-1:0] entry [DEPTH];

    // ==========================================================
    // Pointer wraps silently in both directions
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stackPtr <= '0;
        end else if (push) begin
            stackPtr <= stackPtr + AW'(1); // RULE14
        end else if (pop) begin
            stackPtr <= stackPtr - AW'(1); // RULE15
        end
    end

    // ==========================================================
    // Entry storage, ninth push lands on the first slot
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : gEntry
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    entry[gi] <= '0;
                end else if (push && stackPtr == AW'(gi)) begin
                    entry[gi] <= pushData; // RULE9
                end
            end
        end
    endgenerate

    assign topData = entry[stackPtr - AW'(1)];

endmodule

// >>> hw/pcsi_core.sv
// Purpose: Program counter, return stack and indirect data addressing of an 8-bit core
// Assumes: Decoder strobes arrive from logic on the same clock, one cycle each
// Notes:   Stack pointer has no port; no overflow flag exists
// Operation
// RULE1 - Program counter is thirteen bits and drives every fetch address.
// RULE2 - Low counter byte reads and writes like an ordinary data register.
// RULE3 - Upper five bits are not directly accessible; fed only from high latch. Here step carry, vector and return also load them.
// RULE4 - Any reset clears the whole counter.
// RULE5 - Low byte write copies latch bits 4..0 into counter upper bits.
// RULE6 - Jump or call copies latch bits 4..3 into counter top bits.
// RULE7 - Jump or call takes lower eleven bits from instruction operand.
// RULE8 - Add to low byte never carries into upper bits; software manages blocks.
// RULE9 - Separate return stack of eight entries, thirteen bits each.
// RULE10 - Stack pointer is hidden from every instruction.
// RULE11 - Call and interrupt vectoring push the current counter; a call here pushes the counter plus one.
// RULE12 - Return, literal return and interrupt exit pop into the counter.
// RULE13 - Push and pop leave the high latch unchanged.
// RULE14 - Stack is circular; ninth push overwrites first entry.
// RULE15 - No overflow or underflow flag is raised.
// RULE16 - Indirect port has no storage; accesses go to pointer's location.
// RULE17 - Indirect read of the port itself returns zero.
// RULE18 - Indirect write of the port itself changes nothing.
// RULE19 - Indirect address is bank bit above eight pointer bits.
`timescale 1ns/1ps
module pcsi_core #(
    parameter int          STACK_DEPTH = pcsi_pkg::STACK_DEPTH,
    parameter logic [12:0] INT_VECTOR  = 13'h0004
) (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    // Decoder commands
    input  wire pcsi_pkg::pcsi_cmd_t               cmd,
    // High latch and pointer registers
    input  wire logic [pcsi_pkg::HI_W-1:0]         pcHighLatch,
    input  wire logic [pcsi_pkg::BYTE_W-1:0]       filePointer,
    input  wire logic                              indirectBankBit,
    // Indirect data port access
    input  wire pcsi_pkg::pcsi_ind_t               indReq,
    input  wire logic [pcsi_pkg::BYTE_W-1:0]       fileRdata,
    // Fetch and low byte
    output logic      [pcsi_pkg::PC_W-1:0]         fetchAddr,
    output logic      [pcsi_pkg::BYTE_W-1:0]       pcLowByte,
    // Indirect data path to register file
    output logic      [pcsi_pkg::DADDR_W-1:0]      indAddr,
    output logic                                   fileWrite,
    output logic      [pcsi_pkg::BYTE_W-1:0]       fileWdata,
    output logic      [pcsi_pkg::BYTE_W-1:0]       indRdata
);

    // ==========================================================
    // Local sizes
    localparam int PC_W      = pcsi_pkg::PC_W;
    localparam int BYTE_W    = pcsi_pkg::BYTE_W;
    localparam int HI_W      = pcsi_pkg::HI_W;
    localparam int OPER_W    = pcsi_pkg::OPER_W;
    localparam int DADDR_W   = pcsi_pkg::DADDR_W;
    localparam int JUMP_HI_W = PC_W - OPER_W;

    // ==========================================================
    // Counter state
    logic [PC_W-1:0]      pc;
    logic [PC_W-1:0]      next_pc;
    logic [BYTE_W-1:0]    next_pcLow;
    logic [HI_W-1:0]      next_pcUpper;
    pcsi_pkg::pcsi_load_t loadSel;

    // Candidate counter values
    logic [PC_W-1:0]      stepValue;
    logic [PC_W-1:0]      lowLoadValue;
    logic [PC_W-1:0]      jumpValue;
    logic [JUMP_HI_W-1:0] jumpHigh;

    // Stack interface
    logic [PC_W-1:0]      pushValue;
    logic [PC_W-1:0]      stackTop;
    logic                 doPush;
    logic                 doPop;

    // Indirect path
    logic                 selfRef;
    logic [DADDR_W-1:0]   next_indAddr;
    logic                 next_fileWrite;
    logic [BYTE_W-1:0]    next_indRdata;

    // ==========================================================
    // Load source priority: vector, return, call, jump, low write, step
    always_comb begin
        if (cmd.intVector) begin
            loadSel = pcsi_pkg::PCSI_LD_VEC;
        end else if (cmd.returnPop) begin
            loadSel = pcsi_pkg::PCSI_LD_RET;
        end else if (cmd.callBranch) begin
            loadSel = pcsi_pkg::PCSI_LD_CALL;
        end else if (cmd.directJump) begin
            loadSel = pcsi_pkg::PCSI_LD_JUMP;
        end else if (cmd.writeLow) begin
            loadSel = pcsi_pkg::PCSI_LD_LOW;
        end else if (cmd.advance) begin
            loadSel = pcsi_pkg::PCSI_LD_STEP;
        end else begin
            loadSel = pcsi_pkg::PCSI_LD_HOLD;
        end
    end

    // ==========================================================
    // Stack strobes; the pointer itself stays internal
    assign doPush = (loadSel == pcsi_pkg::PCSI_LD_VEC) ||
                    (loadSel == pcsi_pkg::PCSI_LD_CALL); // RULE11
    assign doPop  = (loadSel == pcsi_pkg::PCSI_LD_RET); // RULE12

    // ==========================================================
    // Plain step carries through all thirteen bits
    // A step past the top wraps to zero
    assign stepValue = pc + pcsi_pkg::PC_ONE;

    // ==========================================================
    // Low byte write: whole latch above it, an add never carries up
    assign lowLoadValue = {pcHighLatch, cmd.lowData}; // RULE5 RULE8

    // ==========================================================
    // Jump or call: only the two top latch bits reach the counter
    assign jumpHigh  = pcHighLatch[HI_W-1 -: JUMP_HI_W]; // RULE6
    assign jumpValue = {jumpHigh, cmd.operand}; // RULE7

    // ==========================================================
    // Return address: a call resumes after itself, an interrupt at
    // the instruction it displaced
    always_comb begin
        case (loadSel)
            pcsi_pkg::PCSI_LD_CALL: begin
                pushValue = stepValue; // RULE11
            end
            pcsi_pkg::PCSI_LD_VEC: begin
                pushValue = pc; // RULE11
            end
            default: begin
                pushValue = stepValue;
            end
        endcase
    end

    // ==========================================================
    // Next low byte
    always_comb begin
        case (loadSel)
            pcsi_pkg::PCSI_LD_STEP: begin
                next_pcLow = stepValue[BYTE_W-1:0];
            end
            pcsi_pkg::PCSI_LD_LOW: begin
                next_pcLow = lowLoadValue[BYTE_W-1:0]; // RULE2
            end
            pcsi_pkg::PCSI_LD_JUMP: begin
                next_pcLow = jumpValue[BYTE_W-1:0]; // RULE7
            end
            pcsi_pkg::PCSI_LD_CALL: begin
                next_pcLow = jumpValue[BYTE_W-1:0]; // RULE7
            end
            pcsi_pkg::PCSI_LD_VEC: begin
                next_pcLow = INT_VECTOR[BYTE_W-1:0];
            end
            pcsi_pkg::PCSI_LD_RET: begin
                next_pcLow = stackTop[BYTE_W-1:0]; // RULE12
            end
            pcsi_pkg::PCSI_LD_HOLD: begin
                next_pcLow = pc[BYTE_W-1:0];
            end
            default: begin
                next_pcLow = pc[BYTE_W-1:0];
            end
        endcase
    end

    // ==========================================================
    // Next upper bits; no path reads or writes them directly
    always_comb begin
        case (loadSel)
            pcsi_pkg::PCSI_LD_STEP: begin
                next_pcUpper = stepValue[PC_W-1:BYTE_W];
            end
            pcsi_pkg::PCSI_LD_LOW: begin
                next_pcUpper = lowLoadValue[PC_W-1:BYTE_W]; // RULE5
            end
            pcsi_pkg::PCSI_LD_JUMP: begin
                next_pcUpper = jumpValue[PC_W-1:BYTE_W]; // RULE6
            end
            pcsi_pkg::PCSI_LD_CALL: begin
                next_pcUpper = jumpValue[PC_W-1:BYTE_W]; // RULE6
            end
            pcsi_pkg::PCSI_LD_VEC: begin
                next_pcUpper = INT_VECTOR[PC_W-1:BYTE_W];
            end
            pcsi_pkg::PCSI_LD_RET: begin
                next_pcUpper = stackTop[PC_W-1:BYTE_W]; // RULE12
            end
            pcsi_pkg::PCSI_LD_HOLD: begin
                next_pcUpper = pc[PC_W-1:BYTE_W];
            end
            default: begin
                next_pcUpper = pc[PC_W-1:BYTE_W];
            end
        endcase
    end

    // Whole next counter
    assign next_pc = {next_pcUpper, next_pcLow};

    // ==========================================================
    // Counter register; upper bits change via the latch paths, step carry, vector or return
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pc <= pcsi_pkg::PC_RESET; // RULE4
        end else begin
            pc <= next_pc; // RULE3
        end
    end

    // ==========================================================
    // Fetch address
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fetchAddr <= pcsi_pkg::PC_RESET; // RULE4
        end else begin
            fetchAddr <= next_pc; // RULE1
        end
    end

    // ==========================================================
    // Readable low byte
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pcLowByte <= pcsi_pkg::ZERO_BYTE;
        end else begin
            pcLowByte <= next_pc[BYTE_W-1:0]; // RULE2
        end
    end

    // ==========================================================
    // Return stack; latch input is not wired in, so never disturbed
    pcsi_return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W)
    ) uStack (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .push     (doPush), // RULE10 RULE13
        .pop      (doPop),
        .pushData (pushValue),
        .topData  (stackTop)
    );

    // ==========================================================
    // Indirect address: bank bit above the pointer
    assign selfRef      = (filePointer == pcsi_pkg::IND_PORT_ADR);
    assign next_indAddr = {indirectBankBit, filePointer}; // RULE19

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            indAddr <= '0;
        end else begin
            indAddr <= next_indAddr; // RULE16
        end
    end

    // ==========================================================
    // Write strobe, dropped when the pointer names the port itself
    assign next_fileWrite = indReq.write && !selfRef; // RULE18

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fileWrite <= 1'b0;
        end else begin
            fileWrite <= next_fileWrite; // RULE16
        end
    end

    // ==========================================================
    // Write data
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fileWdata <= pcsi_pkg::ZERO_BYTE;
        end else begin
            fileWdata <= indReq.wdata;
        end
    end

    // ==========================================================
    // Read data, zero when the pointer names the port itself
    always_comb begin
        if (selfRef) begin
            next_indRdata = pcsi_pkg::ZERO_BYTE; // RULE17
        end else begin
            next_indRdata = fileRdata;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            indRdata <= pcsi_pkg::ZERO_BYTE;
        end else if (indReq.read) begin
            indRdata <= next_indRdata;
        end
    end

endmodule

// >>> verif/pcsi_file_model.sv
// Purpose: Register file behind the indirect data path
// Assumes: Byte-wide file, nine-bit address
// Notes:   Read is combinational from the current address
`timescale 1ns/1ps
module pcsi_file_model (
    // Clock
    input  wire logic       clock,
    // Indirect path
    input  wire logic [8:0] indAddr,
    input  wire logic       fileWrite,
    input  wire logic [7:0] fileWdata,
    output logic      [7:0] fileRdata
);
    logic [7:0] mem [512];
    always_ff @(posedge clock) begin
        if (fileWrite) begin
            mem[indAddr] <= fileWdata;
        end
    end
    assign fileRdata = mem[indAddr];
endmodule

// >>> verif/pcsi_chk.sv
// Purpose: Port assertions for counter, stack and indirect path
// Assumes: Bound to pcsi_core
// Notes:   Strobe priority as in the core
`timescale 1ns/1ps
module pcsi_chk #(
    parameter logic [12:0] INT_VECTOR = 13'h0004
) (
    input wire logic                clock,
    input wire logic                sys_rst,
    input wire pcsi_pkg::pcsi_cmd_t cmd,
    input wire logic [4:0]          pcHighLatch,
    input wire logic [7:0]          filePointer,
    input wire logic                indirectBankBit,
    input wire pcsi_pkg::pcsi_ind_t indReq,
    input wire logic [12:0]         fetchAddr,
    input wire logic [7:0]          pcLowByte,
    input wire logic [8:0]          indAddr,
    input wire logic                fileWrite,
    input wire logic [7:0]          fileWdata,
    input wire logic [7:0]          indRdata
);
    logic [1:0] hiTop;
    logic       jmpLike;
    assign hiTop = pcHighLatch[4:3];
    assign jmpLike = !cmd.intVector && !cmd.returnPop && (cmd.callBranch || cmd.directJump);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_call; cmd.callBranch && !cmd.intVector && !cmd.returnPop; endsequence
    sequence s_ret; cmd.returnPop && !cmd.intVector; endsequence
    sequence s_step; cmd.advance && !cmd.writeLow && !cmd.directJump && !cmd.callBranch
        && !cmd.intVector && !cmd.returnPop; endsequence
    sequence s_vec; cmd.intVector; endsequence
    // ==========================================
    // Counter
    a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> fetchAddr == 13'h0000)
        else $error("counter not cleared");
    a_low_load: assert property (cmd.writeLow && !jmpLike && !cmd.intVector && !cmd.returnPop
        |=> fetchAddr == {$past(pcHighLatch), $past(cmd.lowData)})
        else $error("low byte load wrong");
    a_jump_load: assert property (jmpLike |=> fetchAddr == {$past(hiTop), $past(cmd.operand)})
        else $error("jump load wrong");
    a_call_return: assert property (s_call ##1 s_ret |=> fetchAddr == $past(fetchAddr, 2) + 13'h0001)
        else $error("return address wrong");
    a_vector_load: assert property (cmd.intVector |=> fetchAddr == INT_VECTOR)
        else $error("vector load wrong");
    a_step_count: assert property (s_step |=> fetchAddr == $past(fetchAddr) + 13'h0001)
        else $error("step not by one");
    a_vector_return: assert property (s_vec ##1 s_ret |=> fetchAddr == $past(fetchAddr, 2))
        else $error("interrupt return address wrong");
    a_low_mirror: assert property (pcLowByte == fetchAddr[7:0])
        else $error("low byte differs");
    // ==========================================
    // Indirect path
    a_ind_addr: assert property (1'b1 |=> indAddr == {$past(indirectBankBit), $past(filePointer)})
        else $error("indirect address wrong");
    a_ind_write: assert property (indReq.write && filePointer != 8'h00
        |=> fileWrite && fileWdata == $past(indReq.wdata))
        else $error("indirect write lost");
    a_port_write: assert property (!(indReq.write && filePointer != 8'h00) |=> !fileWrite)
        else $error("stray file write");
    a_port_read: assert property (indReq.read && filePointer == 8'h00 |=> indRdata == 8'h00)
        else $error("port read not zero");
endmodule
bind pcsi_core pcsi_chk #(.INT_VECTOR(INT_VECTOR)) u_chk (.clock(clock), .sys_rst(sys_rst),
    .cmd(cmd), .pcHighLatch(pcHighLatch), .filePointer(filePointer),
    .indirectBankBit(indirectBankBit), .indReq(indReq), .fetchAddr(fetchAddr),
    .pcLowByte(pcLowByte), .indAddr(indAddr), .fileWrite(fileWrite),
    .fileWdata(fileWdata), .indRdata(indRdata));

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for pcsi_core
// Assumes: Inputs change at the falling edge
// Notes:   Bench keeps its own counter and stack image
`timescale 1ns/1ps
module tb_top;
    localparam logic [12:0] VEC = 13'h0004;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    pcsi_pkg::pcsi_cmd_t cmd = '0;
    pcsi_pkg::pcsi_ind_t indReq = '0;
    logic [4:0] pcHighLatch = 5'h00;
    logic [7:0] filePointer = 8'h00;
    logic indirectBankBit = 1'h0;
    logic [7:0] fileRdata, pcLowByte, fileWdata, indRdata;
    logic [12:0] fetchAddr, pc, stk [8];
    logic [8:0] indAddr;
    logic fileWrite;
    logic [2:0] sp = 3'h0;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    pcsi_core #(.INT_VECTOR(VEC)) dut (.clock(clock), .sys_rst(sys_rst), .cmd(cmd),
        .pcHighLatch(pcHighLatch), .filePointer(filePointer),
        .indirectBankBit(indirectBankBit), .indReq(indReq), .fileRdata(fileRdata),
        .fetchAddr(fetchAddr), .pcLowByte(pcLowByte), .indAddr(indAddr),
        .fileWrite(fileWrite), .fileWdata(fileWdata), .indRdata(indRdata));
    pcsi_file_model model (.clock(clock), .indAddr(indAddr), .fileWrite(fileWrite),
        .fileWdata(fileWdata), .fileRdata(fileRdata));
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Strobes: advance, writeLow, directJump, callBranch, intVector, returnPop
    task automatic run(input logic [5:0] s, input logic [10:0] op, input logic [7:0] ld);
        cmd = {s, op, ld};
        @(negedge clock);
    endtask
    task automatic ind(input logic r, input logic w, input logic [7:0] d);
        indReq = {r, w, d};
        @(negedge clock);
    endtask
    task automatic t_reset();
        sys_rst = 1'h1;
        @(negedge clock);
        sys_rst = 1'h0;
        chk("fetchAddr", 13'h0000, fetchAddr);
    endtask
    task automatic t_low();
        pcHighLatch = 5'h15;
        run(6'h10, 11'h000, 8'hF0);
        chk("fetchAddr", 13'h15F0, fetchAddr);
        chk("pcLowByte", 13'h00F0, {5'h00, pcLowByte});
        run(6'h10, 11'h000, 8'hF0 + 8'h20);
        chk("fetchAddr", 13'h1510, fetchAddr);
        run(6'h20, 11'h000, 8'h00);
        chk("fetchAddr", 13'h1511, fetchAddr);
    endtask
    task automatic t_jump();
        pcHighLatch = 5'h17;
        run(6'h08, 11'h2AB, 8'h00);
        pc = 13'h12AB;
        chk("fetchAddr", pc, fetchAddr);
    endtask
    task automatic t_stack();
        logic [10:0] op;
        pcHighLatch = 5'h08;
        for (int i = 0; i < 9; i++) begin
            op = 11'h100 + 11'(i);
            stk[sp] = pc + 13'h0001;
            sp++;
            pc = {2'h1, op};
            run(6'h04, op, 8'h00);
            chk("fetchAddr", pc, fetchAddr);
        end
        stk[sp] = pc;
        sp++;
        pc = VEC;
        run(6'h02, 11'h000, 8'h00);
        chk("fetchAddr", pc, fetchAddr);
        for (int i = 0; i < 10; i++) begin
            sp--;
            pc = stk[sp];
            run(6'h01, 11'h000, 8'h00);
            chk("fetchAddr", pc, fetchAddr);
        end
        stk[sp] = pc + 13'h0001;
        run(6'h04, 11'h055, 8'h00);
        run(6'h01, 11'h000, 8'h00);
        chk("fetchAddr", stk[sp], fetchAddr);
        run(6'h00, 11'h000, 8'h00);
    endtask
    task automatic t_ind();
        filePointer = 8'h20;
        indirectBankBit = 1'h1;
        ind(1'h0, 1'h1, 8'hA5);
        chk("indAddr", 13'h0120, {4'h0, indAddr});
        chk("fileWrite", 13'h0001, {12'h000, fileWrite});
        chk("fileWdata", 13'h00A5, {5'h00, fileWdata});
        ind(1'h0, 1'h0, 8'h00);
        ind(1'h1, 1'h0, 8'h00);
        chk("indRdata", 13'h00A5, {5'h00, indRdata});
        filePointer = 8'h00;
        ind(1'h0, 1'h1, 8'h5A);
        chk("fileWrite", 13'h0000, {12'h000, fileWrite});
        ind(1'h1, 1'h0, 8'h00);
        ind(1'h0, 1'h0, 8'h00);
        chk("indRdata", 13'h0000, {5'h00, indRdata});
    endtask
    initial begin
        repeat (6) @(negedge clock);
        t_reset();
        t_low();
        t_jump();
        t_stack();
        t_ind();
        t_reset();
        report_and_stop();
    end
endmodule
